// File: logic/lbcp_addr_unit.sv
// address pointer with load, add and post increment
// assumes at most one update request per cycle
`timescale 1ns/1ps
module lbcp_addr_unit (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // updates
  input  wire logic        load_lo,
  input  wire logic        load_hi,
  input  wire logic        add_en,
  input  wire logic [7:0]  value,
  // pointer
  output logic      [15:0] addr
);
  logic [15:0] addr_q;                          // pointer register
  logic [15:0] addr_d;                          // next pointer
  // next pointer
  always_comb
  begin
    addr_d = addr_q;
    if (load_lo)
    begin
      addr_d = {addr_q[15:8], value};
    end
    else if (load_hi)
    begin
      addr_d = {value, addr_q[7:0]};
    end
    else if (add_en)
    begin
      addr_d = addr_q + {8'h00, value};
    end
  end
  // register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= 16'h0000;
    end
    else
    begin
      addr_q <= addr_d;
    end
  end
  assign addr = addr_q;
endmodule : lbcp_addr_unit

// File: logic/lbcp_local_read.sv
// local read code lookup: one byte for each local read code
// assumes code is the received byte, unit_addr a parser input, and all other inputs registered state of the parser
`timescale 1ns/1ps
module lbcp_local_read (
  // request
  input  wire logic [7:0]  code,
  // state to report
  input  wire logic [7:0]  unit_addr,
  input  wire logic [7:0]  status,
  input  wire logic [7:0]  crc_count,
  input  wire logic        seq_mem,
  input  wire logic [7:0]  timeout,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  unit_id,
  // answer
  output logic      [7:0]  data
);
  // pick the byte, reserved codes answer zero
  always_comb
  begin
    data = 8'h00;
    case (code)
      lbcp_pkg::RD_UNIT_ADDR: data = unit_addr;
      lbcp_pkg::RD_STATUS:    data = status & lbcp_pkg::STATUS_MASK;
      lbcp_pkg::RD_CRC_EN:    data = 8'h01;
      lbcp_pkg::RD_CRC_CNT:   data = crc_count;
      lbcp_pkg::RD_SEQMEM:    data = {7'h00, seq_mem};
      lbcp_pkg::RD_TIMEOUT:   data = timeout / lbcp_pkg::TIMEOUT_DIV;
      lbcp_pkg::RD_ADDR_LO:   data = addr[7:0];
      lbcp_pkg::RD_ADDR_HI:   data = addr[15:8];
      lbcp_pkg::RD_VERSION:   data = lbcp_pkg::VERSION_VAL;
      lbcp_pkg::RD_UNIT_ID:   data = unit_id;
      lbcp_pkg::RD_PITCH:     data = lbcp_pkg::PITCH_VAL;
      lbcp_pkg::RD_SIZE_LO:   data = lbcp_pkg::TABLE_SIZE_VAL[7:0];
      lbcp_pkg::RD_SIZE_HI:   data = lbcp_pkg::TABLE_SIZE_VAL[15:8];
      lbcp_pkg::RD_CHECK:     data = lbcp_pkg::CHECK_BYTE;
      default:
      begin
        // name characters, else reserved zero
        if (code >= lbcp_pkg::RD_NAME0 && code <= lbcp_pkg::RD_NAME3)
        begin
          data = lbcp_pkg::CARD_NAME[8*code[1:0] +: 8];
        end
        else if (code >= lbcp_pkg::RD_CFG0 && code <= lbcp_pkg::RD_CFG2)
        begin
          data = lbcp_pkg::CFG_NAME[8*(code[1:0]-2'h1) +: 8];
        end
        else
        begin
          data = 8'h00;
        end
      end
    endcase
  end
endmodule : lbcp_local_read

// File: logic/lbcp_parser.sv
// link byte command parser: header decode, data access, local commands
// assumes bytes arrive already framed; crc and memory live outside
`timescale 1ns/1ps
// Functional notes
// - header class 01b is data access
// - bit 5 set writes, clear reads
// - bit 4 picks stored data in sequences
// - bit 3 post increments pointer by length
// - bit 2 adds two address bytes
// - low bits give 1,2,4,8 bytes
// - ascending addresses; pointer kept unless increment
// - sequence byte runs one of 64 lists
// - C0 unit address, C1 status byte
// - status bits 6,5,4,3,0; others reserved
// - C2 always returns 01; E2 crc enable; C3/E3 crc count
// - CA/EA sequence memory access flag
// - EB writes timeout, CB reads it divided by ten
// - D0-D3 card name, D5-D7 configuration
// - D8/D9 pointer, DA version, DB id
// - DC pitch, DD/DE table size
// - DF always returns 5A
// - local writes take one byte, except FF
// - E1 loads status, zero clears errors
// - F8/F9 pointer, FA adds, F7 leds
// - FD stores new unit identifier
// - FE resets on 5A; FF resets parser only when received while idle
module lbcp_parser (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // received byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        in_sequence,
  input  wire logic [7:0]  stored_byte,
  // transmit byte stream
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  // data memory port
  output logic             mem_we,
  output logic             mem_re,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  // stored sequence start
  output logic             seq_start,
  output logic      [5:0]  seq_num,
  // error events
  input  wire logic [7:0]  err_set,
  input  wire logic        crc_err,
  // configuration and indicators
  input  wire logic [7:0]  unit_addr,
  output logic             crc_check_en,
  output logic             seq_mem_access,
  output logic      [7:0]  timeout_chars,
  output logic      [7:0]  leds,
  output logic      [7:0]  unit_id,
  output logic             proc_reset,
  output logic      [15:0] addr_ptr
);
  // parser state
  lbcp_pkg::lbcp_state_t state_q, state_d;      // parser state
  logic [7:0]  hdr_q, hdr_d;                    // captured header or local code
  logic [15:0] cur_q, cur_d;                    // running access address
  logic [3:0]  left_q, left_d;                  // bytes left in access
  // configuration and status
  logic [7:0]  status_q, status_d;              // error flags
  logic [7:0]  crc_cnt_q, crc_cnt_d;            // crc error count
  logic        crc_en_q, crc_en_d;              // crc check enable
  logic        seqmem_q, seqmem_d;              // sequence memory access
  logic [7:0]  tmo_q, tmo_d;                    // timeout in chars
  logic [7:0]  leds_q, leds_d;                  // indicator leds
  logic [7:0]  uid_q, uid_d;                    // unit identifier
  // output registers
  logic        txv_q, txv_d;
  logic [7:0]  txd_q, txd_d;
  logic        we_q, we_d;
  logic        re_q, re_d;
  logic [15:0] ma_q, ma_d;
  logic [7:0]  wd_q, wd_d;
  logic        seq_q, seq_d;
  logic [5:0]  sn_q, sn_d;
  logic        prst_q, prst_d;
  // helpers
  logic        ptr_lo, ptr_hi, ptr_add;         // pointer updates
  logic [7:0]  ptr_val;                         // pointer update value
  logic [15:0] ptr;                             // current pointer
  logic [7:0]  local_rd;                        // local read answer
  logic [7:0]  wbyte;                           // write data source

  // transfer length in bytes from the header
  function automatic logic [3:0] xfer_len(input logic [7:0] h);
    xfer_len = 4'h1 << h[1:0];
  endfunction : xfer_len

  // pointer unit
  lbcp_addr_unit u_addr (
    .clk     (clk),
    .rst     (rst),
    .load_lo (ptr_lo),
    .load_hi (ptr_hi),
    .add_en  (ptr_add),
    .value   (ptr_val),
    .addr    (ptr)
  );

  // local read lookup
  lbcp_local_read u_lrd (
    .code      (rx_data),
    .unit_addr (unit_addr),
    .status    (status_q),
    .crc_count (crc_cnt_q),
    .seq_mem   (seqmem_q),
    .timeout   (tmo_q),
    .addr      (ptr),
    .unit_id   (uid_q),
    .data      (local_rd)
  );

  // stored data only counts inside a sequence
  assign wbyte = (in_sequence && hdr_q[lbcp_pkg::BIT_STORED]) ? stored_byte : rx_data;

  // next state of parser and registers
  always_comb
  begin
    state_d   = state_q;
    hdr_d     = hdr_q;
    cur_d     = cur_q;
    left_d    = left_q;
    status_d  = status_q | (err_set & lbcp_pkg::STATUS_MASK);
    crc_cnt_d = crc_cnt_q;
    crc_en_d  = crc_en_q;
    seqmem_d  = seqmem_q;
    tmo_d     = tmo_q;
    leds_d    = leds_q;
    uid_d     = uid_q;
    txv_d     = 1'b0;
    txd_d     = txd_q;
    we_d      = 1'b0;
    re_d      = 1'b0;
    ma_d      = ma_q;
    wd_d      = wd_q;
    seq_d     = 1'b0;
    sn_d      = sn_q;
    prst_d    = 1'b0;
    ptr_lo    = 1'b0;
    ptr_hi    = 1'b0;
    ptr_add   = 1'b0;
    ptr_val   = rx_data;
    // memory answers combinationally while its read strobe stands
    if (re_q)
    begin
      txv_d = 1'b1;
      txd_d = mem_rdata;
    end
    if (crc_err)
    begin
      crc_cnt_d = crc_cnt_q + 8'h01;
    end
    if (rx_valid)
    begin
      case (state_q)
        lbcp_pkg::LBCP_IDLE:
        begin
          hdr_d  = rx_data;
          cur_d  = ptr;
          left_d = xfer_len(rx_data);
          if (rx_data[lbcp_pkg::CLASS_HI:lbcp_pkg::CLASS_LO] == lbcp_pkg::CLASS_DATA)
          begin
            if (rx_data[lbcp_pkg::BIT_ADDRLEN])
            begin
              state_d = lbcp_pkg::LBCP_ADR_LO;
            end
            else if (rx_data[lbcp_pkg::BIT_WRITE])
            begin
              state_d = lbcp_pkg::LBCP_WDATA;
            end
            else
            begin
              state_d = lbcp_pkg::LBCP_RDATA;
            end
          end
          else if (rx_data[lbcp_pkg::CLASS_HI:lbcp_pkg::CLASS_LO] == lbcp_pkg::CLASS_SEQ)
          begin
            seq_d = 1'b1;
            sn_d  = rx_data[lbcp_pkg::SEQ_NUM_W-1:0];
          end
          else if (rx_data[7:5] == 3'h6)
          begin
            txv_d = 1'b1;
            txd_d = local_rd;
          end
          else if (rx_data[7:5] == 3'h7)
          begin
            // local write: wait for its byte, except parser reset
            if (rx_data != lbcp_pkg::WR_PARSE_RESET)
            begin
              state_d = lbcp_pkg::LBCP_LOCWR;
            end
            else
            begin
              state_d = lbcp_pkg::LBCP_IDLE;
            end
          end
        end
        lbcp_pkg::LBCP_ADR_LO:
        begin
          cur_d   = {cur_q[15:8], rx_data};
          ptr_lo  = hdr_q[lbcp_pkg::BIT_POSTINC];               // pointer follows address when post increment set
          state_d = lbcp_pkg::LBCP_ADR_HI;
        end
        lbcp_pkg::LBCP_ADR_HI:
        begin
          cur_d   = {rx_data, cur_q[7:0]};
          ptr_hi  = hdr_q[lbcp_pkg::BIT_POSTINC];               // pointer follows address when post increment set
          state_d = hdr_q[lbcp_pkg::BIT_WRITE] ? lbcp_pkg::LBCP_WDATA : lbcp_pkg::LBCP_RDATA;
        end
        lbcp_pkg::LBCP_WDATA:
        begin
          we_d   = 1'b1;
          ma_d   = cur_q;
          wd_d   = wbyte;
          cur_d  = cur_q + 16'h0001;
          left_d = left_q - 4'h1;
          if (left_q == 4'h1)
          begin
            state_d = lbcp_pkg::LBCP_IDLE;
            ptr_add = hdr_q[lbcp_pkg::BIT_POSTINC];
            ptr_val = {4'h0, xfer_len(hdr_q)};
          end
        end
        lbcp_pkg::LBCP_LOCWR:
        begin
          state_d = lbcp_pkg::LBCP_IDLE;
          case (hdr_q)
            lbcp_pkg::WR_STATUS:  status_d  = (rx_data & lbcp_pkg::STATUS_MASK)
                                              | (err_set & lbcp_pkg::STATUS_MASK);
            lbcp_pkg::WR_CRC_EN:  crc_en_d  = (rx_data != 8'h00);
            lbcp_pkg::WR_CRC_CNT: crc_cnt_d = rx_data;
            lbcp_pkg::WR_SEQMEM:  seqmem_d  = (rx_data != 8'h00);
            lbcp_pkg::WR_TIMEOUT: tmo_d     = rx_data;
            lbcp_pkg::WR_LEDS:    leds_d    = rx_data;
            lbcp_pkg::WR_ADDR_LO: ptr_lo    = 1'b1;
            lbcp_pkg::WR_ADDR_HI: ptr_hi    = 1'b1;
            lbcp_pkg::WR_ADDR_ADD: ptr_add  = 1'b1;
            lbcp_pkg::WR_UNIT_ID: uid_d     = rx_data;
            lbcp_pkg::WR_PROC_RESET: prst_d = (rx_data == lbcp_pkg::CHECK_BYTE);
            default: state_d = lbcp_pkg::LBCP_IDLE;
          endcase
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
    // read bytes are paced by the parser, not by rx
    if (state_q == lbcp_pkg::LBCP_RDATA)
    begin
      re_d   = 1'b1;
      ma_d   = cur_q;
      cur_d  = cur_q + 16'h0001;
      left_d = left_q - 4'h1;
      if (left_q == 4'h1)
      begin
        state_d = lbcp_pkg::LBCP_IDLE;
        ptr_add = hdr_q[lbcp_pkg::BIT_POSTINC];
        ptr_val = {4'h0, xfer_len(hdr_q)};
      end
    end
    // parser reset code returns to idle only when received while idle, not during a command
    if (rx_valid && rx_data == lbcp_pkg::WR_PARSE_RESET && state_q == lbcp_pkg::LBCP_IDLE)
    begin
      state_d = lbcp_pkg::LBCP_IDLE;
    end
    if (prst_d)
    begin
      status_d  = err_set & lbcp_pkg::STATUS_MASK;              // new error wins
      crc_cnt_d = 8'h00;
      seqmem_d  = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= lbcp_pkg::LBCP_IDLE;
      hdr_q     <= 8'h00;
      cur_q     <= 16'h0000;
      left_q    <= 4'h0;
      status_q  <= 8'h00;
      crc_cnt_q <= 8'h00;
      crc_en_q  <= 1'b1;
      seqmem_q  <= 1'b0;
      tmo_q     <= lbcp_pkg::TIMEOUT_RST;
      leds_q    <= 8'h00;
      uid_q     <= lbcp_pkg::UNIT_ID_RST;
      txv_q     <= 1'b0;
      txd_q     <= 8'h00;
      we_q      <= 1'b0;
      re_q      <= 1'b0;
      ma_q      <= 16'h0000;
      wd_q      <= 8'h00;
      seq_q     <= 1'b0;
      sn_q      <= 6'h00;
      prst_q    <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      hdr_q     <= hdr_d;
      cur_q     <= cur_d;
      left_q    <= left_d;
      status_q  <= status_d;
      crc_cnt_q <= crc_cnt_d;
      crc_en_q  <= crc_en_d;
      seqmem_q  <= seqmem_d;
      tmo_q     <= tmo_d;
      leds_q    <= leds_d;
      uid_q     <= uid_d;
      txv_q     <= txv_d;
      txd_q     <= txd_d;
      we_q      <= we_d;
      re_q      <= re_d;
      ma_q      <= ma_d;
      wd_q      <= wd_d;
      seq_q     <= seq_d;
      sn_q      <= sn_d;
      prst_q    <= prst_d;
    end
  end

  // outputs
  assign tx_valid       = txv_q;
  assign tx_data        = txd_q;
  assign mem_we         = we_q;
  assign mem_re         = re_q;
  assign mem_addr       = ma_q;
  assign mem_wdata      = wd_q;
  assign seq_start      = seq_q;
  assign seq_num        = sn_q;
  assign crc_check_en   = crc_en_q;
  assign seq_mem_access = seqmem_q;
  assign timeout_chars  = tmo_q;
  assign leds           = leds_q;
  assign unit_id        = uid_q;
  assign proc_reset     = prst_q;
  assign addr_ptr       = ptr;
endmodule : lbcp_parser

// File: logic/lbcp_pkg.sv
// package for the link byte command parser: codes, fields, reset values
// assumes the parser sees one received byte per rx_valid strobe
package lbcp_pkg;
  // header fields
  localparam int          CLASS_HI       = 7;                 // class field top bit
  localparam int          CLASS_LO       = 6;                 // class field low bit
  localparam logic [1:0]  CLASS_DATA     = 2'h1;              // data read/write class
  localparam logic [1:0]  CLASS_SEQ      = 2'h2;              // stored sequence class
  localparam int          BIT_WRITE      = 5;                 // direction bit
  localparam int          BIT_STORED     = 4;                 // stored_data_flag
  localparam int          BIT_POSTINC    = 3;                 // post_increment_bit
  localparam int          BIT_ADDRLEN    = 2;                 // address_length_bit
  localparam int          SEQ_NUM_W      = 6;                 // 64 sequences
  // local read codes
  localparam logic [7:0]  RD_UNIT_ADDR   = 8'hC0;
  localparam logic [7:0]  RD_STATUS      = 8'hC1;
  localparam logic [7:0]  RD_CRC_EN      = 8'hC2;
  localparam logic [7:0]  RD_CRC_CNT     = 8'hC3;
  localparam logic [7:0]  RD_SEQMEM      = 8'hCA;
  localparam logic [7:0]  RD_TIMEOUT     = 8'hCB;
  localparam logic [7:0]  RD_NAME0       = 8'hD0;
  localparam logic [7:0]  RD_NAME3       = 8'hD3;
  localparam logic [7:0]  RD_CFG0        = 8'hD5;
  localparam logic [7:0]  RD_CFG2        = 8'hD7;
  localparam logic [7:0]  RD_ADDR_LO     = 8'hD8;
  localparam logic [7:0]  RD_ADDR_HI     = 8'hD9;
  localparam logic [7:0]  RD_VERSION     = 8'hDA;
  localparam logic [7:0]  RD_UNIT_ID     = 8'hDB;
  localparam logic [7:0]  RD_PITCH       = 8'hDC;
  localparam logic [7:0]  RD_SIZE_LO     = 8'hDD;
  localparam logic [7:0]  RD_SIZE_HI     = 8'hDE;
  localparam logic [7:0]  RD_CHECK       = 8'hDF;
  // local write codes
  localparam logic [7:0]  WR_STATUS      = 8'hE1;
  localparam logic [7:0]  WR_CRC_EN      = 8'hE2;
  localparam logic [7:0]  WR_CRC_CNT     = 8'hE3;
  localparam logic [7:0]  WR_SEQMEM      = 8'hEA;
  localparam logic [7:0]  WR_TIMEOUT     = 8'hEB;
  localparam logic [7:0]  WR_LEDS        = 8'hF7;
  localparam logic [7:0]  WR_ADDR_LO     = 8'hF8;
  localparam logic [7:0]  WR_ADDR_HI     = 8'hF9;
  localparam logic [7:0]  WR_ADDR_ADD    = 8'hFA;
  localparam logic [7:0]  WR_UNIT_ID     = 8'hFD;
  localparam logic [7:0]  WR_PROC_RESET  = 8'hFE;
  localparam logic [7:0]  WR_PARSE_RESET = 8'hFF;
  localparam logic [7:0]  CHECK_BYTE     = 8'h5A;             // check byte and reset key
  // status bits
  localparam int          ST_TIMEOUT     = 6;
  localparam int          ST_PROTECT     = 5;
  localparam int          ST_OVERFLOW    = 4;
  localparam int          ST_WATCHDOG    = 3;
  localparam int          ST_CRC         = 0;
  localparam logic [7:0]  STATUS_MASK    = 8'h79;             // implemented status bits
  // reset and constant values
  localparam logic [7:0]  TIMEOUT_RST    = 8'hFF;             // character times
  localparam logic [7:0]  TIMEOUT_DIV    = 8'h0A;             // read scale
  localparam logic [7:0]  VERSION_VAL    = 8'h01;             // arbitrary value
  localparam logic [7:0]  UNIT_ID_RST    = 8'h00;
  localparam logic [7:0]  PITCH_VAL      = 8'h08;
  localparam logic [15:0] TABLE_SIZE_VAL = 16'h0200;
  localparam logic [31:0] CARD_NAME      = 32'h4B524158;      // arbitrary value
  localparam logic [23:0] CFG_NAME       = 24'h474643;        // arbitrary value
  // parser states
  typedef enum logic [5:0] {
    LBCP_IDLE   = 6'h01,                                      // waiting for header
    LBCP_ADR_LO = 6'h02,                                      // address low byte
    LBCP_ADR_HI = 6'h04,                                      // address high byte
    LBCP_WDATA  = 6'h08,                                      // data write bytes
    LBCP_RDATA  = 6'h10,                                      // data read bytes
    LBCP_LOCWR  = 6'h20                                       // local write data
  } lbcp_state_t;
endpackage : lbcp_pkg

// File: tb/lbcp_mem_model.sv
// partner: byte memory behind the parser data port
// assumes writes land on the clock edge, reads follow the address
`timescale 1ns/1ps
module lbcp_mem_model (
  // clock
  input  wire logic        clk,
  // memory port
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] m [256];                            // low 256 bytes of data space
  initial foreach (m[i]) m[i] = 8'h00;
  // one byte stored per strobe at its own address
  always @(posedge clk)
    if (mem_we) m[mem_addr[7:0]] <= mem_wdata;
  assign mem_rdata = m[mem_addr[7:0]];
endmodule : lbcp_mem_model

// File: tb/lbcp_monitor.sv
// checker: timing relations seen at the parser ports
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
module lbcp_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // byte streams and memory port
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        in_sequence,
  input wire logic        tx_valid,
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  // control outputs
  input wire logic        seq_start,
  input wire logic [5:0]  seq_num,
  input wire logic        proc_reset,
  input wire logic        crc_check_en,
  input wire logic [7:0]  timeout_chars
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // single memory read and write strobes
  sequence rd_req;
    mem_re;
  endsequence
  sequence wr_req;
    mem_we;
  endsequence
  rd_answer_a: assert property (rd_req |=> tx_valid)
    else $error("read byte not answered");
  rd_burst_a: assert property (rd_req ##1 rd_req |-> mem_addr == $past(mem_addr) + 16'h1)
    else $error("read burst not ascending");
  wr_burst_a: assert property (wr_req ##1 wr_req |-> mem_addr == $past(mem_addr) + 16'h1)
    else $error("write burst not ascending");
  wdata_src_a: assert property (mem_we && !$past(in_sequence)
    |-> $past(rx_valid) && mem_wdata == $past(rx_data))
    else $error("write data not from stream");
  tx_cause_a: assert property (tx_valid |-> $past(rx_valid) || $past(mem_re))
    else $error("answer byte without cause");
  seq_num_a: assert property (seq_start |-> $past(rx_valid)
    && {2'h0, seq_num} == ($past(rx_data) & 8'h3F))
    else $error("wrong sequence number");
  proc_key_a: assert property (proc_reset |-> $past(rx_valid)
    && $past(rx_data) == lbcp_pkg::CHECK_BYTE)
    else $error("processor reset without key");
  proc_once_a: assert property (proc_reset |=> !proc_reset)
    else $error("processor reset too long");
  rst_vals_a: assert property ($fell(rst) |-> crc_check_en && timeout_chars == lbcp_pkg::TIMEOUT_RST)
    else $error("wrong reset settings");
endmodule : lbcp_monitor
bind lbcp_parser lbcp_monitor i_lbcp_monitor (.clk(clk), .rst(rst), .rx_valid(rx_valid),
  .rx_data(rx_data), .in_sequence(in_sequence), .tx_valid(tx_valid), .mem_we(mem_we),
  .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .seq_start(seq_start),
  .seq_num(seq_num), .proc_reset(proc_reset), .crc_check_en(crc_check_en),
  .timeout_chars(timeout_chars));

// File: tb/testbench.sv
// testbench: command bytes in, answers and settings checked
// assumes parser with memory model; checker bound to the parser
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic [7:0]  err_set = 8'h00;
  logic        crc_err = 1'b0;
  logic        in_seq = 1'b0;                     // command comes from a stored sequence
  logic        tx_valid, mem_we, mem_re, seq_start, crc_en, seq_mem, proc_reset;
  logic [7:0]  tx_data, mem_wdata, mem_rdata, tmo, leds, unit_id;
  logic [15:0] mem_addr, addr_ptr;
  logic [5:0]  seq_num, last_seq;
  logic [7:0]  tx_q[$];                           // answer bytes in order
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_proc = 0;                        // processor reset pulses
  always #10 clk = ~clk;
  lbcp_parser i_lbcp_parser (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .in_sequence(in_seq), .stored_byte(8'h3D), .tx_valid(tx_valid), .tx_data(tx_data),
    .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .seq_start(seq_start), .seq_num(seq_num), .err_set(err_set),
    .crc_err(crc_err), .unit_addr(8'h3C), .crc_check_en(crc_en), .seq_mem_access(seq_mem),
    .timeout_chars(tmo), .leds(leds), .unit_id(unit_id), .proc_reset(proc_reset),
    .addr_ptr(addr_ptr));
  lbcp_mem_model i_lbcp_mem_model (.clk(clk), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // collect answers, pulses and sequence numbers
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1) tx_q.push_back(tx_data);
    if (proc_reset === 1'b1) n_proc++;
    if (seq_start === 1'b1) last_seq = seq_num;
  end
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // bytes back to back, one per edge, then settle
  task automatic cmd(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(posedge clk);
      #1 rx_valid = 1'b1;
      rx_data = b[i];
    end
    @(posedge clk);
    #1 rx_valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : cmd
  // wait a bounded time for each answer byte
  task automatic rds(input logic [7:0] e[$]);
    int w;
    foreach (e[i])
    begin
      w = 0;
      while (tx_q.size() == 0 && w < 50)
      begin
        @(posedge clk);
        w++;
      end
      if (tx_q.size() == 0) chk(16'hFFFF, e[i]);
      else chk(tx_q.pop_front(), e[i]);
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : rds
  // one error event pulse
  task automatic pulse(input logic [7:0] e, input logic c);
    @(posedge clk);
    #1 err_set = e;
    crc_err = c;
    @(posedge clk);
    #1 err_set = 8'h00;
    crc_err = 1'b0;
  endtask : pulse
  initial
  begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk(tmo, lbcp_pkg::TIMEOUT_RST);
    cmd({8'h6E, 8'h10, 8'h00, 8'hAA, 8'hBB, 8'hCC, 8'hDD});
    chk(addr_ptr, 16'h0014);
    cmd({8'hF8, 8'h14, 8'hF9, 8'h00, 8'h69, 8'hEE, 8'hFF});
    chk(addr_ptr, 16'h0016);
    cmd({8'h61, 8'h11, 8'h22});
    chk(addr_ptr, 16'h0016);
    cmd({8'h47, 8'h10, 8'h00});
    rds({8'hAA, 8'hBB, 8'hCC, 8'hDD, 8'hEE, 8'hFF, 8'h11, 8'h22});
    cmd({8'h4A});
    rds({8'h11, 8'h22, 8'h00, 8'h00});
    chk(addr_ptr, 16'h001A);
    cmd({8'hFA, 8'hF6, 8'h40});
    rds({8'hAA});
    cmd({8'hD8, 8'hD9});
    rds({8'h10, 8'h01});
    cmd({8'hC0, 8'hDF, 8'hDA, 8'hDC, 8'hDD, 8'hDE, 8'hCB, 8'hC4, 8'hC2, 8'hD0, 8'hD7});
    rds({8'h3C, 8'h5A, lbcp_pkg::VERSION_VAL, lbcp_pkg::PITCH_VAL,
      lbcp_pkg::TABLE_SIZE_VAL[7:0], lbcp_pkg::TABLE_SIZE_VAL[15:8], 8'h19, 8'h00,
      8'h01, lbcp_pkg::CARD_NAME[7:0], lbcp_pkg::CFG_NAME[23:16]});
    cmd({8'hEB, 8'h28, 8'hF7, 8'hA5, 8'hFD, 8'h77, 8'hE3, 8'h05});
    chk(tmo, 16'h0028);
    chk(leds, 16'h00A5);
    chk(unit_id, 16'h0077);
    pulse(8'h00, 1'b1);
    cmd({8'hCB, 8'hDB, 8'hC3});
    rds({8'h04, 8'h77, 8'h06});
    cmd({8'hEA, 8'h01, 8'hE2, 8'h00});
    chk(seq_mem, 16'h0001);
    chk(crc_en, 16'h0000);
    cmd({8'hEA, 8'h00});
    chk(seq_mem, 16'h0000);
    pulse(8'hFF, 1'b0);
    cmd({8'hC1});
    rds({8'h79});
    cmd({8'hE0, 8'h33, 8'hE1, 8'h00, 8'hC1});
    rds({8'h00});
    chk(leds, 16'h00A5);
    cmd({8'h85});
    chk(last_seq, 16'h0005);
    cmd({8'hFE, 8'h11});
    chk(16'(n_proc), 16'h0000);
    cmd({8'hFE, 8'h5A});
    chk(16'(n_proc), 16'h0001);
    cmd({8'hFF, 8'hDF});
    rds({8'h5A});
    in_seq = 1'b1;
    cmd({8'h74, 8'h30, 8'h00, 8'h99});
    in_seq = 1'b0;
    cmd({8'h74, 8'h31, 8'h00, 8'h55, 8'h45, 8'h30, 8'h00});
    rds({8'h3D, 8'h55});
    print_verdict();
  end
endmodule : testbench
